// File: hdl/tdu_top.sv
// Trigger decision unit: primitive matching, merging, choke/error handling.
// Assumes primitive valid/tag/cond inputs are same-clock logic; choke, error
// and forced lines are pins and pass a two-stage synchroniser.
`timescale 1ns/100ps
module tdu_top (
    input wire logic CLK_SYS_I,
    input wire logic RST_N_I,
    input wire logic [tdu_pkg::TW-1:0] NOW_TAG_I,
    input wire logic [tdu_pkg::TW-1:0] LATENCY_MAX_I,
    input wire logic [tdu_pkg::NSRC-1:0] PRIM_VALID_I,
    input wire logic [tdu_pkg::NSRC*tdu_pkg::TW-1:0] PRIM_TAG_I,
    input wire logic [tdu_pkg::NCOND*tdu_pkg::NSRC-1:0] COND_SRC_MASK_I,
    input wire logic [tdu_pkg::NCOND*tdu_pkg::TW-1:0] COND_WINDOW_I,
    input wire logic [tdu_pkg::NCOND-1:0] COND_ENABLE_I,
    input wire logic [tdu_pkg::TW-1:0] MERGE_SEP_I,
    input wire logic [15:0] DOWNSCALE_I,
    input wire logic CALIB_REQ_I,
    input wire logic MONITOR_REQ_I,
    input wire logic FORCE_PULSE_I,
    input wire logic [tdu_pkg::NSRC-1:0] CHOKE_I,
    input wire logic [tdu_pkg::NSRC-1:0] ERROR_I,
    input wire logic [tdu_pkg::NSRC-1:0] CHOKE_MASK_I,
    input wire logic [tdu_pkg::NSRC-1:0] ERROR_MASK_I,
    input wire logic LOG_CLEAR_I,
    output logic ACCEPT_STROBE_O,
    output logic [tdu_pkg::TW-1:0] ACCEPT_TAG_O,
    output logic [tdu_pkg::TTW-1:0] ACCEPT_TYPE_O,
    output logic TYPE_SER_O,
    output logic CHOKED_O,
    output logic [tdu_pkg::NSRC-1:0] CHOKE_LOG_O,
    output logic [tdu_pkg::NSRC-1:0] ERROR_LOG_O
);
    logic [1:0] rst_sync_r;
    logic rst_n;
    logic [tdu_pkg::NSRC*2+1-1:0] pin_s1_r, pin_s2_r;
    logic [tdu_pkg::NSRC-1:0] choke_s, err_s;
    logic force_s, force_d_r;
    logic choke_any, err_any, choke_st_r, err_st_r;
    logic [tdu_pkg::TW-1:0] cand_tag_r, cand_tag_nxt;
    logic [tdu_pkg::TTW-1:0] cand_type_r, cand_type_nxt;
    logic cand_v_r, cand_v_nxt;
    logic cand_seen_r;
    logic cand_go;
    logic [tdu_pkg::TW-1:0] last_tag_r [tdu_pkg::NSRC];
    logic [tdu_pkg::NSRC-1:0] seen_r;
    logic [tdu_pkg::NCOND-1:0] cond_hit;
    logic [15:0] ds_cnt_r;
    logic [7:0] force_cnt_r;
    logic force_due;
    logic [5:0] grid_acc_r;
    logic grid_tick;
    logic tx_busy;
    logic [3:0] spec_pend_r;
    logic phys_ok;

    function automatic logic [tdu_pkg::TW-1:0] tdiff(input logic [tdu_pkg::TW-1:0] a,
                                                     input logic [tdu_pkg::TW-1:0] b);
        tdiff = (a >= b) ? a - b : b - a;
    endfunction : tdiff

    // Reset release through two flip-flops
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
        end else begin
            pin_s1_r <= {FORCE_PULSE_I, ERROR_I, CHOKE_I};
            pin_s2_r <= pin_s1_r;
        end
    end
    assign choke_s = pin_s2_r[tdu_pkg::NSRC-1:0];
    assign err_s = pin_s2_r[2*tdu_pkg::NSRC-1:tdu_pkg::NSRC];
    assign force_s = pin_s2_r[2*tdu_pkg::NSRC];
    assign choke_any = |(choke_s & ~CHOKE_MASK_I);
    assign err_any = |(err_s & ~ERROR_MASK_I);

    // activity log, set wins over clear
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            CHOKE_LOG_O <= '0;
            ERROR_LOG_O <= '0;
        end else begin
            CHOKE_LOG_O <= (LOG_CLEAR_I ? '0 : CHOKE_LOG_O) | choke_s;
            ERROR_LOG_O <= (LOG_CLEAR_I ? '0 : ERROR_LOG_O) | err_s;
        end
    end

    // latest primitive per source, aged by latency
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            seen_r <= '0;
            for (int i = 0; i < tdu_pkg::NSRC; i++) last_tag_r[i] <= tdu_pkg::TAG_RST;
        end else begin
            for (int i = 0; i < tdu_pkg::NSRC; i++) begin
                if (PRIM_VALID_I[i]) begin
                    last_tag_r[i] <= PRIM_TAG_I[i*tdu_pkg::TW +: tdu_pkg::TW];
                    seen_r[i] <= 1'b1;
                end
            end
        end
    end

    always_comb begin
        logic [tdu_pkg::TW-1:0] ref_tag;
        logic ok;
        ok = 1'b0;
        ref_tag = NOW_TAG_I - LATENCY_MAX_I;
        cond_hit = '0;
        for (int c = 0; c < tdu_pkg::NCOND; c++) begin
            ok = COND_ENABLE_I[c] && |COND_SRC_MASK_I[c*tdu_pkg::NSRC +: tdu_pkg::NSRC];
            for (int i = 0; i < tdu_pkg::NSRC; i++) begin
                if (COND_SRC_MASK_I[c*tdu_pkg::NSRC+i]) begin
                    ok = ok && seen_r[i] && tdiff(last_tag_r[i], ref_tag) <=
                         COND_WINDOW_I[c*tdu_pkg::TW +: tdu_pkg::TW];
                end
            end
            cond_hit[c] = ok;
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            ds_cnt_r <= 16'h0000;
            force_cnt_r <= 8'h00;
            force_d_r <= 1'b0;
        end else begin
            force_d_r <= force_s;
            if (|cond_hit) ds_cnt_r <= (ds_cnt_r >= DOWNSCALE_I) ? 16'h0000 : ds_cnt_r + 16'h0001;
            if (force_s && !force_d_r && force_cnt_r == 8'h00) begin
                force_cnt_r <= 8'(tdu_pkg::FORCE_DELAY_CYC);
            end else if (force_cnt_r != 8'h00) begin
                force_cnt_r <= force_cnt_r - 8'h01;
            end
        end
    end
    assign force_due = force_cnt_r == 8'h01;

    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            choke_st_r <= 1'b0;
            err_st_r <= 1'b0;
            spec_pend_r <= 4'h0;
        end else begin
            choke_st_r <= choke_any;
            err_st_r <= err_any;
            spec_pend_r[0] <= spec_pend_r[0] | (choke_any & ~choke_st_r);
            spec_pend_r[1] <= spec_pend_r[1] | (~choke_any & choke_st_r);
            spec_pend_r[2] <= spec_pend_r[2] | (err_any & ~err_st_r);
            spec_pend_r[3] <= spec_pend_r[3] | (~err_any & err_st_r);
            if (grid_tick && !tx_busy) begin
                // Highest-priority pending special is sent; others wait
                if (spec_pend_r[0]) spec_pend_r[0] <= 1'b0;
                else if (spec_pend_r[1]) spec_pend_r[1] <= 1'b0;
                else if (spec_pend_r[2]) spec_pend_r[2] <= 1'b0;
                else if (spec_pend_r[3]) spec_pend_r[3] <= 1'b0;
            end
        end
    end
    assign CHOKED_O = choke_st_r;
    assign phys_ok = !choke_st_r && !err_st_r && spec_pend_r == 4'h0;
    // held candidate waits out a choke instead of slipping through
    assign cand_go = grid_tick && !tx_busy && cand_v_r && phys_ok;

    // 25 ns grid from 8 ns clock
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            grid_acc_r <= tdu_pkg::GRID_ACC_RST;
        end else if (grid_acc_r + 6'(tdu_pkg::CLK_NS) >= 6'(tdu_pkg::GRID_NS)) begin
            grid_acc_r <= grid_acc_r + 6'(tdu_pkg::CLK_NS) - 6'(tdu_pkg::GRID_NS);
        end else begin
            grid_acc_r <= grid_acc_r + 6'(tdu_pkg::CLK_NS);
        end
    end
    assign grid_tick = grid_acc_r + 6'(tdu_pkg::CLK_NS) >= 6'(tdu_pkg::GRID_NS);

    always_comb begin
        logic [tdu_pkg::TW-1:0] t;
        logic [tdu_pkg::TTW-1:0] ty;
        logic nv;
        t = NOW_TAG_I - LATENCY_MAX_I;
        nv = 1'b0;
        ty = tdu_pkg::TYPE_PHYS_BASE;
        cand_v_nxt = cand_v_r;
        cand_tag_nxt = cand_tag_r;
        cand_type_nxt = cand_type_r;
        if (phys_ok) begin
            for (int c = tdu_pkg::NCOND - 1; c >= 0; c--) begin
                if (cond_hit[c]) begin
                    nv = 1'b1;
                    ty = tdu_pkg::TYPE_PHYS_BASE + 6'(c);
                end
            end
            if (nv && ds_cnt_r == 16'h0000 && DOWNSCALE_I != 16'h0000) ty = tdu_pkg::TYPE_DOWNSCALED;
            if (!nv && CALIB_REQ_I) begin
                nv = 1'b1;
                ty = tdu_pkg::TYPE_CALIB;
            end
            if (!nv && MONITOR_REQ_I) begin
                nv = 1'b1;
                ty = tdu_pkg::TYPE_MONITOR;
            end
            if (!nv && force_due) begin
                nv = 1'b1;
                ty = tdu_pkg::TYPE_FORCED;
                t = NOW_TAG_I;
            end
        end
        if (cand_go) cand_v_nxt = 1'b0;
        if (nv) begin
            // Merging also against a just-sent candidate, so a match that lasts
            // several cycles cannot re-trigger
            if ((cand_v_r || cand_seen_r) && tdiff(t, cand_tag_r) < MERGE_SEP_I) begin
                cand_v_nxt = cand_v_nxt; // Merged: first tag kept
            end else if (!cand_v_nxt) begin
                cand_v_nxt = 1'b1;
                cand_tag_nxt = t;
                cand_type_nxt = ty;
            end
        end
    end
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            cand_v_r <= 1'b0;
            cand_seen_r <= 1'b0;
            cand_tag_r <= tdu_pkg::TAG_RST;
            cand_type_r <= tdu_pkg::TYPE_PHYS_BASE;
        end else begin
            cand_v_r <= cand_v_nxt;
            cand_seen_r <= cand_seen_r | cand_v_r;
            cand_tag_r <= cand_tag_nxt;
            cand_type_r <= cand_type_nxt;
        end
    end

    // accept strobe, specials ahead of physics
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            ACCEPT_STROBE_O <= 1'b0;
            ACCEPT_TAG_O <= tdu_pkg::TAG_RST;
            ACCEPT_TYPE_O <= tdu_pkg::TYPE_PHYS_BASE;
        end else begin
            ACCEPT_STROBE_O <= 1'b0;
            if (grid_tick && !tx_busy) begin
                if (spec_pend_r != 4'h0) begin
                    ACCEPT_STROBE_O <= 1'b1;
                    ACCEPT_TAG_O <= NOW_TAG_I;
                    ACCEPT_TYPE_O <= spec_pend_r[0] ? tdu_pkg::TYPE_CHOKE_ON :
                                     spec_pend_r[1] ? tdu_pkg::TYPE_CHOKE_OFF :
                                     spec_pend_r[2] ? tdu_pkg::TYPE_ERR_ON : tdu_pkg::TYPE_ERR_OFF;
                end else if (cand_go) begin
                    ACCEPT_STROBE_O <= 1'b1;
                    ACCEPT_TAG_O <= cand_tag_r;
                    ACCEPT_TYPE_O <= cand_type_r;
                end
            end
        end
    end

    tdu_word_tx u_tx (
        .clk_i(CLK_SYS_I),
        .rst_n_i(rst_n),
        .load_i(ACCEPT_STROBE_O),
        .word_i(ACCEPT_TYPE_O),
        .busy_o(tx_busy),
        .ser_o(TYPE_SER_O)
    );

    a_strobe_single: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
        ACCEPT_STROBE_O |=> !ACCEPT_STROBE_O) else $error("accept strobe longer than one cycle");
    a_word_follows: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
        ACCEPT_STROBE_O |=> tx_busy && TYPE_SER_O) else $error("type word did not follow strobe");
    a_choke_on_sent: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
        choke_any && !choke_st_r |-> ##[1:300] (ACCEPT_STROBE_O && ACCEPT_TYPE_O == tdu_pkg::TYPE_CHOKE_ON))
        else $error("choke-on trigger missing");
    a_no_phys_choked: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
        ACCEPT_STROBE_O && $past(choke_st_r) && $past(spec_pend_r) == 4'h0 |-> 1'b0)
        else $error("physics trigger issued while choked");
    a_err_on_pend: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
        err_any && !err_st_r |=> spec_pend_r[2]) else $error("error-on not pending");
    a_err_off_pend: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
        !err_any && err_st_r |=> spec_pend_r[3]) else $error("error-off not pending");
    a_choke_off_pend: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
        !choke_any && choke_st_r |=> spec_pend_r[1]) else $error("choke-off not pending");
    a_log_sets: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
        |choke_s |=> |CHOKE_LOG_O) else $error("choke activity not logged");
    c_phys_accept: cover property (@(posedge CLK_SYS_I) ACCEPT_STROBE_O && ACCEPT_TYPE_O < 6'h04);
    c_choke_cycle: cover property (@(posedge CLK_SYS_I) ACCEPT_TYPE_O == tdu_pkg::TYPE_CHOKE_OFF);
    c_forced: cover property (@(posedge CLK_SYS_I) ACCEPT_STROBE_O && ACCEPT_TYPE_O == tdu_pkg::TYPE_FORCED);
endmodule : tdu_top

// File: hdl/tdu_pkg.sv
// Package with constants for the trigger decision unit.
// Assumes one 125 MHz system clock; the 25 ns grid is derived from it.
// Overview of operation
// - After primitive_latency_max, match primitive tags against programmable condition windows.
// - Several conditions are evaluated in parallel, each with its own window.
// - Down-scaled control, calibration and monitoring triggers are also produced.
// - Candidates closer than a programmable separation merge into one trigger.
// - Each pending candidate holds a time tag and type word until sent.
// - Accepted candidates give a synchronous accept_strobe on the 25 ns grid.
// - A 6-bit type word follows each accept_strobe on the serial line.
// - A forced-trigger pulse schedules a special trigger after a constant delay.
// - Choke and error lines are watched and their activity logged always.
// - Unmasked choke rising sends choke-on trigger, then triggering stops.
// - All unmasked chokes low sends choke-off trigger, normal triggering resumes.
// - Unmasked error rising sends an error-on trigger.
// - All unmasked errors low sends an error-off trigger before normal operation.
package tdu_pkg;
    localparam int NSRC = 4;
    localparam int NCOND = 4;
    localparam int TW = 16;
    localparam int TTW = 6;
    localparam int CLK_NS = 8;
    localparam int GRID_NS = 25;
    // Grid ticks come every 3 sys cycles, every eighth after 4 (25 cycles per 8 ticks); accumulate ns to stay on average grid
    localparam logic [5:0] GRID_ACC_RST = 6'h00;
    localparam int FORCE_DELAY_NS = 400;
    localparam int FORCE_DELAY_CYC = (FORCE_DELAY_NS + CLK_NS - 1) / CLK_NS;
    localparam int WORD_BIT_NS = 100;
    localparam int WORD_BIT_CYC = (WORD_BIT_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [TTW-1:0] TYPE_CHOKE_ON = 6'h3C;
    localparam logic [TTW-1:0] TYPE_CHOKE_OFF = 6'h3D;
    localparam logic [TTW-1:0] TYPE_ERR_ON = 6'h3E;
    localparam logic [TTW-1:0] TYPE_ERR_OFF = 6'h3F;
    localparam logic [TTW-1:0] TYPE_FORCED = 6'h38;
    localparam logic [TTW-1:0] TYPE_DOWNSCALED = 6'h39;
    localparam logic [TTW-1:0] TYPE_CALIB = 6'h3A;
    localparam logic [TTW-1:0] TYPE_MONITOR = 6'h3B;
    localparam logic [TTW-1:0] TYPE_PHYS_BASE = 6'h00;
    localparam logic [TW-1:0] TAG_RST = 16'h0000;
endpackage : tdu_pkg

// File: hdl/tdu_word_tx.sv
// Serial sender of the trigger type word after each accept strobe.
// Assumes one load at a time; busy holds off the next load.
`timescale 1ns/100ps
module tdu_word_tx (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic load_i,
    input wire logic [tdu_pkg::TTW-1:0] word_i,
    output logic busy_o,
    output logic ser_o
);
    logic [tdu_pkg::TTW+1:0] sh_r;
    logic [3:0] bits_r;
    logic [7:0] div_r;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sh_r <= '0;
            bits_r <= 4'h0;
            div_r <= 8'h00;
        end else if (load_i && bits_r == 4'h0) begin
            sh_r <= {1'b1, word_i, 1'b1}; // Start bit first, stop bit last
            bits_r <= 4'(tdu_pkg::TTW + 2);
            div_r <= 8'(tdu_pkg::WORD_BIT_CYC - 1);
        end else if (bits_r != 4'h0) begin
            if (div_r == 8'h00) begin
                sh_r <= {1'b0, sh_r[tdu_pkg::TTW+1:1]};
                bits_r <= bits_r - 4'h1;
                div_r <= 8'(tdu_pkg::WORD_BIT_CYC - 1);
            end else begin
                div_r <= div_r - 8'h01;
            end
        end
    end
    assign busy_o = bits_r != 4'h0;
    assign ser_o = busy_o & sh_r[0];
endmodule : tdu_word_tx

// File: tb/tdu_rx_model.sv
// Far-side readout model: counts accept strobes and decodes the serial type word.
// Assumes the frame is a start bit, six bits LSB first and a stop bit, idle low.
`timescale 1ns/100ps
module tdu_rx_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic strobe_i,
    input wire logic [tdu_pkg::TW-1:0] tag_i,
    input wire logic ser_i,
    output logic [tdu_pkg::TTW-1:0] word_o,
    output logic word_v_o,
    output int event_no_o,
    output logic [tdu_pkg::TW-1:0] req_tag_o
);
    logic [tdu_pkg::TTW-1:0] sh;

    // event per strobe
    // Every strobe opens a frame, empty or special ones included
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            event_no_o <= 0;
            req_tag_o <= '0;
        end else if (strobe_i) begin
            event_no_o <= event_no_o + 1;
            req_tag_o <= tag_i;
        end
    end

    // word recovery for forwarding
    // Mid-bit sampling tolerates a cycle of skew on the start edge
    initial begin
        word_o = '0;
        word_v_o = 1'b0;
        forever begin
            @(posedge clk_i iff (ser_i === 1'b1 && rst_n_i === 1'b1));
            repeat (tdu_pkg::WORD_BIT_CYC / 2) @(posedge clk_i);
            for (int k = 0; k < tdu_pkg::TTW; k++) begin
                repeat (tdu_pkg::WORD_BIT_CYC) @(posedge clk_i);
                sh[k] = ser_i;
            end
            repeat (tdu_pkg::WORD_BIT_CYC) @(posedge clk_i);
            word_o <= (ser_i === 1'b1) ? sh : ~sh; // Bad stop bit spoils the word
            word_v_o <= 1'b1;
            @(posedge clk_i);
            word_v_o <= 1'b0;
            @(posedge clk_i iff ser_i !== 1'b1);
        end
    end
endmodule : tdu_rx_model

// File: tb/level0_trigger_decision_bench.sv
// Bench of the trigger decision unit: table of physics cases, then specials,
// merging, downscale, choke and error handling and a mid-run reset.
// Assumes tdu_rx_model sits on the strobe and serial word outputs.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin \
    n_compared++; \
    if ((got) !== (ex)) begin \
        error_cnt++; \
        $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); \
    end \
end
module level0_trigger_decision_bench;
    typedef struct packed {logic [3:0] en; logic [3:0] src; logic [3:0] off; logic fire; logic [5:0] typ;} tdu_row_s;
    localparam logic [15:0] LAT = 16'h0010;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] now_tag = 16'h0100;
    logic [3:0] pv = 4'h0;
    logic [63:0] ptag = 64'h0;
    logic [3:0] cen = 4'hF;
    logic [15:0] dscale = 16'h0000;
    logic calib = 1'b0;
    logic mon = 1'b0;
    logic frc = 1'b0;
    logic [3:0] chk = 4'h0;
    logic [3:0] err = 4'h0;
    logic [3:0] chk_m = 4'h0;
    logic [3:0] err_m = 4'h0;
    logic lclr = 1'b0;
    logic stb;
    logic ser;
    logic choked;
    logic [15:0] atag;
    logic [5:0] atyp;
    logic [3:0] clog;
    logic [3:0] elog;
    logic [5:0] rx_word;
    logic word_v;
    int ev_no;
    int error_cnt = 0;
    int n_compared = 0;
    int n_trig = 0;
    logic [5:0] t1;
    logic [5:0] t2;
    int w;
    tdu_row_s rows [9] = '{
        '{4'hF, 4'h1, 4'h0, 1'b1, 6'h00}, // Cond0 centre
        '{4'hF, 4'h1, 4'h2, 1'b1, 6'h00}, // Cond0 upper window edge
        '{4'hF, 4'h1, 4'hE, 1'b1, 6'h00}, // Cond0 lower window edge
        '{4'hF, 4'h1, 4'hD, 1'b0, 6'h00}, // Just outside the window
        '{4'hF, 4'h6, 4'h1, 1'b1, 6'h01}, // Two-source condition
        '{4'hF, 4'h2, 4'h0, 1'b0, 6'h00}, // Only one of its sources
        '{4'hF, 4'h8, 4'h0, 1'b1, 6'h02}, // Zero-width window
        '{4'hF, 4'hF, 4'hD, 1'b1, 6'h03}, // Only the wide condition holds
        '{4'hB, 4'h8, 4'h0, 1'b0, 6'h00}  // Cond2 disabled
    };

    // Free-running time tag, advanced on the edge itself
    always @(posedge clk) now_tag <= now_tag + 16'h0001;

    tdu_top u_tdu_top (.CLK_SYS_I(clk), .RST_N_I(rst_n), .NOW_TAG_I(now_tag), .LATENCY_MAX_I(LAT),
        .PRIM_VALID_I(pv), .PRIM_TAG_I(ptag), .COND_SRC_MASK_I(16'hF861),
        .COND_WINDOW_I(64'h0003_0000_0001_0002), .COND_ENABLE_I(cen), .MERGE_SEP_I(16'h0008),
        .DOWNSCALE_I(dscale), .CALIB_REQ_I(calib), .MONITOR_REQ_I(mon), .FORCE_PULSE_I(frc),
        .CHOKE_I(chk), .ERROR_I(err), .CHOKE_MASK_I(chk_m), .ERROR_MASK_I(err_m), .LOG_CLEAR_I(lclr),
        .ACCEPT_STROBE_O(stb), .ACCEPT_TAG_O(atag), .ACCEPT_TYPE_O(atyp), .TYPE_SER_O(ser),
        .CHOKED_O(choked), .CHOKE_LOG_O(clog), .ERROR_LOG_O(elog));

    tdu_rx_model u_tdu_rx_model (.clk_i(clk), .rst_n_i(rst_n), .strobe_i(stb), .tag_i(atag), .ser_i(ser),
        .word_o(rx_word), .word_v_o(word_v), .event_no_o(ev_no), .req_tag_o());

    // Clock of 8 ns period
    initial begin
        forever #4 clk = ~clk;
    end

    // Inputs move 1 ns after the rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic hit(input logic [3:0] src, input logic [3:0] off);
        tick(1);
        pv = src;
        // Offset is taken against the reference of the first cycle that sees the tag
        for (int i = 0; i < 4; i++) ptag[i*16 +: 16] = now_tag + 16'h0001 - LAT + {{12{off[3]}}, off};
        tick(1);
        pv = 4'h0;
    endtask : hit

    // Bounded wait for a strobe, then the serial word behind it
    task automatic catch_trig(output logic [5:0] t, output int waited);
        int k;
        waited = 0;
        k = 0;
        while (stb !== 1'b1 && waited < 400) begin
            tick(1);
            waited++;
        end
        `CHK("strobe", 1'b1, stb)
        t = atyp;
        tick(1);
        `CHK("strobe width", 1'b0, stb)
        `CHK("start bit", 1'b1, ser)
        while (word_v !== 1'b1 && k < 150) begin
            tick(1);
            k++;
        end
        `CHK("serial word", t, rx_word)
        `CHK("type held", t, atyp)
        n_trig++;
    endtask : catch_trig

    task automatic expect_trig(input logic [5:0] typ);
        logic [5:0] t;
        int k;
        catch_trig(t, k);
        `CHK("type", typ, t)
    endtask : expect_trig

    task automatic no_trig(input int n);
        repeat (n) begin
            tick(1);
            `CHK("no strobe", 1'b0, stb)
        end
    endtask : no_trig

    task automatic stop_test;
        if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test

    // Watchdog well beyond the expected run of about 3200 cycles
    initial begin
        #(40000 * 8);
        error_cnt++;
        stop_test();
    end

    initial begin
        tick(3);
        `CHK("outputs in reset", 11'h000, {stb, ser, choked, clog, elog})
        rst_n = 1'b1;
        tick(6);
        foreach (rows[r]) begin
            cen = rows[r].en;
            hit(rows[r].src, rows[r].off);
            if (rows[r].fire) expect_trig(rows[r].typ);
            else no_trig(200);
        end
        cen = 4'hF;
        for (int i = 0; i < 2; i++) begin
            tick(1);
            calib = (i == 0);
            mon = (i == 1);
            tick(1);
            calib = 1'b0;
            mon = 1'b0;
            expect_trig(i == 0 ? tdu_pkg::TYPE_CALIB : tdu_pkg::TYPE_MONITOR);
        end
        // forced trigger after its fixed delay
        frc = 1'b1;
        tick(2);
        frc = 1'b0;
        catch_trig(t1, w);
        `CHK("forced", {tdu_pkg::TYPE_FORCED, 1'b1}, {t1, w + 2 >= tdu_pkg::FORCE_DELAY_CYC})
        hit(4'h1, 4'h0);
        hit(4'h1, 4'h0);
        expect_trig(6'h00);
        no_trig(150);
        dscale = 16'h0001;
        hit(4'h1, 4'h0);
        catch_trig(t1, w);
        hit(4'h1, 4'h0);
        catch_trig(t2, w);
        `CHK("downscale", 1'b1, {t1, t2} === 12'hE40 || {t1, t2} === 12'h039)
        dscale = 16'h0000;
        // choke stops physics, error-on still passes
        chk = 4'h2;
        expect_trig(tdu_pkg::TYPE_CHOKE_ON);
        `CHK("choked", 1'b1, choked)
        hit(4'h1, 4'h0);
        no_trig(150);
        err = 4'h4;
        expect_trig(tdu_pkg::TYPE_ERR_ON);
        chk = 4'h0;
        expect_trig(tdu_pkg::TYPE_CHOKE_OFF);
        `CHK("choke released", 1'b0, choked)
        err = 4'h0;
        expect_trig(tdu_pkg::TYPE_ERR_OFF);
        hit(4'h1, 4'h0);
        expect_trig(6'h00);
        chk_m = 4'h8;
        err_m = 4'h8;
        chk = 4'h8;
        err = 4'h8;
        no_trig(150);
        `CHK("logs", 9'h0AC, {choked, clog, elog})
        chk = 4'h0;
        err = 4'h0;
        // Let the synchroniser drain, else the set-wins log refills at once
        tick(3);
        lclr = 1'b1;
        tick(1);
        lclr = 1'b0;
        tick(2);
        `CHK("logs cleared", 8'h00, {clog, elog})
        `CHK("events", n_trig, ev_no)
        // Reset in mid-word must silence the serial line
        calib = 1'b1;
        tick(1);
        calib = 1'b0;
        tick(30);
        rst_n = 1'b0;
        tick(1);
        `CHK("mid reset", 3'h0, {stb, ser, choked})
        rst_n = 1'b1;
        tick(40);
        `CHK("idle after reset", 1'b0, ser)
        no_trig(100);
        stop_test();
    end
endmodule : level0_trigger_decision_bench
